/* rtl/video_field_line_sequencer.sv */
// Vertical-interval line sequencer and subcarrier synthesizer control.
//
// Functional notes
// - Every output line gets one of the listed line types.
// - With blanking enable set, black-and-burst lines become active video.
// - With blanking enable set, burstless blank lines become burstless video.
// - 625-line PAL: eight fields, 3-bit index, lines 1-1250, 313 starts field 2.
// - 625-line PAL field 1 line types per line ranges.
// - 625-line PAL field 2 line types per line ranges.
// - PAL-M: eight fields of 525-line frames; field 1 line types.
// - PAL-M field 2 line types per line ranges.
// - PAL-M fields 3 and 4 differ at lines 8, 259 and 522.
// - Subcarrier comes from an internal synthesizer with fixed values.
// - Master mode resynchronizes the subcarrier on field 1.
// - Subcarrier phase stays correct across all eight fields.
// - Field 1 reset phases: NTSC 180 at line 4, PAL-M line 4, PAL line 1.
// - Reset phase is relative to the reset line's horizontal reference.
// - Sync-to-burst phase is held at its defined value.
// - NTSC holds the same sync-to-burst phase on every line.
// - Subcarrier frequency chosen per standard; line rate per line count.
// - NTSC: four fields, 2-bit index; field 1 line types.
// - Embedded-sync slave mode holds line end until the next EAV.
`timescale 1ns/1ps
`default_nettype none
`include "line_seq_cfg.svh"

module video_field_line_sequencer (
    // Clock and reset.
    input  wire logic                     clk_i,
    input  wire logic                     rst_b_i,
    // Mode selection.
    input  wire line_seq_pkg::std_t       std_i,
    input  wire logic                     master_mode_i,
    input  wire logic                     blanking_lines_active_enable_i,
    // End-of-active-video marker from the pixel stream decoder.
    input  wire logic                     eav_strobe_i,
    // Line sequence.
    output wire line_seq_pkg::line_kind_t line_type_o,
    output wire logic [2:0]               field_index_o,
    output wire logic [10:0]              line_number_o,
    output wire logic                     line_start_o,
    output wire logic                     eol_hold_o,
    // Subcarrier.
    output wire logic                     sc_reset_o,
    output wire logic [9:0]               sc_phase_o
);
    import line_seq_pkg::*;

    seq_reg_t    cur;
    seq_reg_t    nxt;
    logic        eav_edge;
    logic        boundary;
    logic [11:0] last_cyc;
    sc_ctrl_if   sc ();

    function automatic logic is_625(input std_t s);
        is_625 = (s == std_pal_bgh) || (s == std_pal_n);
    endfunction : is_625

    function automatic logic [31:0] step_of(input std_t s);
        unique case (s)
            std_ntsc:    step_of = `STEP_NTSC;
            std_pal_bgh: step_of = `STEP_PAL;
            std_pal_m:   step_of = `STEP_PALM;
            std_pal_n:   step_of = `STEP_PALN;
        endcase
    endfunction : step_of

    function automatic logic field_start(input std_t s, input logic [10:0] l);
        field_start = (l == `FIELD1_LINE);
        if (s == std_ntsc)
            field_start = field_start || (l == `FIELD2_NTSC);
        else if (s == std_pal_m)
            field_start = field_start || (l == `FIELD2_PALM);
        else
            field_start = field_start || (l == `FIELD2_625) ||
                          (l == `FIELD3_625) || (l == `FIELD4_625);
    endfunction : field_start

    // Line type of line l in field f; line ranges follow each standard's
    // vertical interval, with the blanking enable applied last.
    function automatic line_kind_t classify(input std_t s, input int l,
                                            input logic [2:0] f,
                                            input logic en);
        line_kind_t k;
        int         m;
        logic       b;
        k = active_video_line;
        m = l;
        b = 1'b0;
        if (s == std_ntsc)
        begin
            if (l <= 3 || (l >= 7 && l <= 9) || l == 264 || l == 265 ||
                l == 270 || l == 271)
                k = equalization_line;
            else if ((l >= 4 && l <= 6) || l == 267 || l == 268)
                k = vertical_sync_line;
            else if (l == 266)
                k = eq_then_sync_line;
            else if (l == 269)
                k = sync_then_eq_line;
            else if (l == 272)
                k = eq_broad_line;
            else if ((l >= 10 && l <= 20) || (l >= 273 && l <= 282))
                k = black_burst_line;
            else if (l == 263)
                k = video_then_eq_line;
        end
        else if (s == std_pal_m)
        begin
            if (l <= 3 || l == 264 || l == 265)
                k = vertical_sync_line;
            else if ((l >= 4 && l <= 6) || l == 261 || l == 262 ||
                     l == 267 || l == 268 || l >= 523)
                k = equalization_line;
            else if (l == 266)
                k = sync_then_eq_line;
            else if (l == 263)
                k = eq_then_sync_line;
            else if (l == 269)
                k = eq_broad_line;
            else if (l == 7 || l == 270 || (l == 8 && !f[1]))
                k = blank_no_burst_line;
            else if ((l >= 8 && l <= 17) || (l >= 271 && l <= 279))
                k = black_burst_line;
            else if ((l == 259 && f[1]) || (l == 522 && !f[1]))
                k = active_no_burst_line;
            else if (l == 260)
                k = video_eq_no_burst_line;
        end
        else
        begin
            b = (l > 625);
            m = b ? l - 625 : l;
            if (m <= 2 || m == 314 || m == 315)
                k = vertical_sync_line;
            else if (m == 3)
                k = sync_then_eq_line;
            else if (m == 313)
                k = eq_then_sync_line;
            else if (m == 4 || m == 5 || m == 311 || m == 312 ||
                     m == 316 || m == 317 || m >= 624)
                k = equalization_line;
            else if (m == 318)
                k = eq_broad_line;
            else if ((m == 6 && !b) || (m == 319 && b))
                k = blank_no_burst_line;
            else if ((m >= 6 && m <= 22) || (m >= 319 && m <= 335))
                k = black_burst_line;
            else if ((m == 310 || m == 622) && !b)
                k = active_no_burst_line;
            else if (m == 623)
                k = video_eq_no_burst_line;
        end
        if (en && k == black_burst_line)
            k = active_video_line;
        if (en && k == blank_no_burst_line)
            k = active_no_burst_line;
        classify = k;
    endfunction : classify

    always_comb
    begin
        nxt = cur;
        nxt.start = 1'b0;
        nxt.sc_load = 1'b0;
        nxt.sc_rst = 1'b0;
        nxt.step = step_of(std_i);
        // Marker input: a change counts once the two later stages agree.
        nxt.eav_sync = {cur.eav_sync[1:0], eav_strobe_i};
        eav_edge = 1'b0;
        if (cur.eav_sync[2] == cur.eav_sync[1])
        begin
            nxt.eav_lvl = cur.eav_sync[2];
            eav_edge = cur.eav_sync[2] & ~cur.eav_lvl;
        end
        last_cyc = is_625(std_i) ? 12'(`LINE_CYC_625 - 1)
                                 : 12'(`LINE_CYC_525 - 1);
        boundary = 1'b0;
        unique case (cur.st)
            st_count:
            begin
                if (!master_mode_i && eav_edge)
                    boundary = 1'b1;
                else if (cur.cnt != last_cyc)
                    nxt.cnt = cur.cnt + 12'h001;
                else if (master_mode_i)
                    boundary = 1'b1;
                else
                begin
                    nxt.st = st_hold;
                    nxt.hold = 1'b1;
                end
            end
            st_hold:
            begin
                if (master_mode_i || eav_edge)
                    boundary = 1'b1;
            end
        endcase
        if (boundary)
        begin
            nxt.st = st_count;
            nxt.hold = 1'b0;
            nxt.cnt = 12'h000;
            nxt.start = 1'b1;
            // Line and field counters; the field index wraps to field 1.
            if (cur.line >= (is_625(std_i) ? `LAST_LINE_625 : `LAST_LINE_525))
                nxt.line = `FIELD1_LINE;
            else
                nxt.line = cur.line + 11'h001;
            if (field_start(std_i, nxt.line))
            begin
                if (std_i == std_ntsc)
                    nxt.field_index = {1'b0, cur.field_index[1:0] + 2'h1};
                else
                    nxt.field_index = cur.field_index + 3'h1;
            end
            nxt.kind = classify(std_i, int'(nxt.line), nxt.field_index,
                                blanking_lines_active_enable_i);
            // NTSC has 227.5 subcarrier cycles per line, so the phase at
            // each line start alternates; reloading it every line keeps
            // the sync-to-burst phase exact despite step rounding.
            if (std_i == std_ntsc)
            begin
                nxt.sc_load = 1'b1;
                nxt.sc_val = cur.ntsc_odd ? `SC_PHASE_0 : `SC_PHASE_180;
                nxt.ntsc_odd = ~cur.ntsc_odd;
            end
            if (master_mode_i && nxt.field_index == `SC_RESET_FIELD &&
                nxt.line == (is_625(std_i) ? `SC_RESET_LINE_625
                                           : `SC_RESET_LINE_525))
            begin
                nxt.sc_load = 1'b1;
                nxt.sc_rst = 1'b1;
                nxt.ntsc_odd = (std_i == std_ntsc);
                nxt.sc_val = (std_i == std_ntsc) ? `SC_PHASE_180
                                                 : `SC_PHASE_0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur <= '0;
            cur.st <= st_count;
            cur.line <= `RESET_LINE;
            cur.field_index <= `RESET_FIELD;
            cur.kind <= equalization_line;
        end
        else
            cur <= nxt;
    end

    // Reloads at the line's horizontal reference fix the sync-to-burst
    // phase; the synthesizer carries it on between loads.
    assign sc.step     = cur.step;
    assign sc.load     = cur.sc_load;
    assign sc.load_val = cur.sc_val;

    subcarrier_synth synth_u (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .sc      (sc.synth)
    );

    assign line_type_o   = cur.kind;
    assign field_index_o = cur.field_index;
    assign line_number_o = cur.line;
    assign line_start_o  = cur.start;
    assign eol_hold_o    = cur.hold;
    assign sc_reset_o    = cur.sc_rst;
    assign sc_phase_o    = sc.phase;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    vbi_black_a : assert property (line_start_o && $past(
        blanking_lines_active_enable_i) |-> line_type_o != black_burst_line
    ) else $error("Black line kept under blanking enable.");

    vbi_blank_a : assert property (line_start_o && $past(
        blanking_lines_active_enable_i) |-> line_type_o != blank_no_burst_line
    ) else $error("Blank line kept under blanking enable.");

    pal_field_a : assert property (line_start_o &&
        is_625($past(std_i)) && line_number_o == `FIELD2_625 |->
        field_index_o == $past(field_index_o) + 3'h1
    ) else $error("Field index did not step at line 313.");

    pal_f1_a : assert property (line_start_o &&
        is_625($past(std_i)) && line_number_o == 11'h136 |-> line_type_o ==
        active_no_burst_line) else $error("Line 310 not burstless video.");

    pal_f2_a : assert property (line_start_o &&
        is_625($past(std_i)) && line_number_o == 11'h13E |-> line_type_o ==
        eq_broad_line) else $error("Line 318 not broad pulse.");

    palm_f1_a : assert property (line_start_o &&
        $past(std_i) == std_pal_m && line_number_o == 11'h104 |-> line_type_o
        == video_eq_no_burst_line) else $error("Line 260 not half video.");

    palm_f2_a : assert property (line_start_o &&
        $past(std_i) == std_pal_m && line_number_o == 11'h10D |->
        line_type_o == eq_broad_line) else $error("Line 269 not broad pulse.");

    palm_f3_a : assert property (line_start_o &&
        $past(std_i) == std_pal_m && field_index_o[1] &&
        line_number_o == 11'h008 && !$past(blanking_lines_active_enable_i)
        |-> line_type_o == black_burst_line
    ) else $error("Field 3 line 8 not black and burst.");

    ntsc_f1_a : assert property (line_start_o &&
        $past(std_i) == std_ntsc && line_number_o == 11'h107 |-> line_type_o
        == video_then_eq_line) else $error("Line 263 not half video.");

    sc_reset_a : assert property (sc_reset_o |-> line_start_o &&
        field_index_o == `SC_RESET_FIELD && $past(master_mode_i)
    ) else $error("Subcarrier reset off field 1.");

    sc_phase_a : assert property (sc_reset_o |=> sc_phase_o ==
        ($past(std_i, 2) == std_ntsc ? 10'h200 : 10'h000)
    ) else $error("Wrong subcarrier reset phase.");

    ntsc_line_a : assert property (line_start_o &&
        $past(std_i) == std_ntsc |=> sc_phase_o[8:0] == 9'h000
    ) else $error("NTSC line phase not aligned.");

    hold_end_a : assert property ($fell(eol_hold_o) |->
        line_start_o) else $error("Line end hold left without a line start.");

    line_step_a : assert property (line_start_o |->
        line_number_o == `FIELD1_LINE || line_number_o == $past(line_number_o)
        + 11'h001) else $error("Line counter skipped.");

endmodule : video_field_line_sequencer

`default_nettype wire

/* pkg/line_seq_cfg.svh */
// Numbering, timing and subcarrier constants of the field/line sequencer.
`ifndef LINE_SEQ_CFG_SVH
`define LINE_SEQ_CFG_SVH

// Clock period and rate.
`define CLK_PS             25000
`define CLK_MHZ            40.0

// Line periods in ns and the derived whole-cycle counts.
`define LINE_NS_525        63556
`define LINE_NS_625        64000
`define LINE_CYC_525       ((`LINE_NS_525 * 1000) / `CLK_PS)
`define LINE_CYC_625       ((`LINE_NS_625 * 1000) / `CLK_PS)

// Last line of each numbering cycle.
`define LAST_LINE_525      11'h20D
`define LAST_LINE_625      11'h4E2

// First line of each field.
`define FIELD1_LINE        11'h001
`define FIELD2_NTSC        11'h108
`define FIELD2_PALM        11'h107
`define FIELD2_625         11'h139
`define FIELD3_625         11'h272
`define FIELD4_625         11'h3AA

// State after reset: the first line boundary lands on line 1, field 1.
`define RESET_LINE         11'h000
`define RESET_FIELD        3'h7

// Subcarrier reset line and phases.
`define SC_RESET_LINE_525  11'h004
`define SC_RESET_LINE_625  11'h001
`define SC_RESET_FIELD     3'h0
`define SC_PHASE_0         32'h0000_0000
`define SC_PHASE_180       32'h8000_0000

// Subcarrier frequencies in MHz and phase steps per clock.
`define FSC_NTSC_MHZ       3.579545455
`define FSC_PAL_MHZ        4.43361875
`define FSC_PALM_MHZ       3.57561189
`define FSC_PALN_MHZ       3.58205625
`define STEP_NTSC  32'($rtoi(`FSC_NTSC_MHZ / `CLK_MHZ * 4294967296.0))
`define STEP_PAL   32'($rtoi(`FSC_PAL_MHZ / `CLK_MHZ * 4294967296.0))
`define STEP_PALM  32'($rtoi(`FSC_PALM_MHZ / `CLK_MHZ * 4294967296.0))
`define STEP_PALN  32'($rtoi(`FSC_PALN_MHZ / `CLK_MHZ * 4294967296.0))

`endif

/* pkg/line_seq_pkg.sv */
// Types shared by the field/line sequencer and its subcarrier synthesizer.
`default_nettype none

package line_seq_pkg;

    typedef enum logic [1:0] {
        std_ntsc    = 2'h0,
        std_pal_bgh = 2'h1,
        std_pal_m   = 2'h2,
        std_pal_n   = 2'h3
    } std_t;

    typedef enum logic [3:0] {
        equalization_line      = 4'h0,
        vertical_sync_line     = 4'h1,
        sync_then_eq_line      = 4'h2,
        eq_then_sync_line      = 4'h3,
        eq_broad_line          = 4'h4,
        black_burst_line       = 4'h5,
        active_video_line      = 4'h6,
        video_then_eq_line     = 4'h7,
        blank_no_burst_line    = 4'h8,
        active_no_burst_line   = 4'h9,
        video_eq_no_burst_line = 4'hA
    } line_kind_t;

    typedef enum logic [1:0] {
        st_count = 2'b01,
        st_hold  = 2'b10
    } seq_state_t;

    typedef struct packed {
        seq_state_t  st;
        logic [11:0] cnt;
        logic [10:0] line;
        logic [2:0]  field_index;
        line_kind_t  kind;
        logic        start;
        logic        hold;
        logic        sc_load;
        logic        sc_rst;
        logic [31:0] sc_val;
        logic [31:0] step;
        logic        ntsc_odd;
        logic [2:0]  eav_sync;
        logic        eav_lvl;
    } seq_reg_t;

    typedef struct packed {
        logic [31:0] acc;
    } synth_reg_t;

endpackage : line_seq_pkg

`default_nettype wire

/* pkg/sc_ctrl_if.sv */
// Control and phase signals between the sequencer and the synthesizer.
`timescale 1ns/1ps
`default_nettype none

interface sc_ctrl_if;
    logic [31:0] step;
    logic        load;
    logic [31:0] load_val;
    logic [9:0]  phase;

    modport ctrl  (output step, output load, output load_val, input phase);
    modport synth (input step, input load, input load_val, output phase);
endinterface : sc_ctrl_if

`default_nettype wire

/* rtl/subcarrier_synth.sv */
// Phase-accumulating subcarrier synthesizer with a phase load.
`timescale 1ns/1ps
`default_nettype none

module subcarrier_synth (
    // Clock and reset.
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    // Control from the sequencer.
    sc_ctrl_if.synth    sc
);
    import line_seq_pkg::*;

    synth_reg_t cur;
    synth_reg_t nxt;

    // The step holds the standard's frequency offsets, so phase runs on
    // unbroken between loads across all eight fields.
    always_comb
    begin
        nxt = cur;
        if (sc.load)
            nxt.acc = sc.load_val;
        else
            nxt.acc = cur.acc + sc.step;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign sc.phase = cur.acc[31:22];

    phase_load_a : assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        sc.load |=> cur.acc == $past(sc.load_val))
        else $error("Subcarrier phase not loaded.");

    phase_run_a : assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !sc.load |=> cur.acc == $past(cur.acc) + $past(sc.step))
        else $error("Subcarrier phase broke between loads.");

endmodule : subcarrier_synth

`default_nettype wire

/* tb/pixel_source_model.sv */
// Pixel stream source model that marks the end of each line's active video.
`timescale 1ns/1ps
`default_nettype none

module pixel_source_model (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Line request from the bench.
    input  wire logic run_i,
    // Marker toward the sequencer.
    output wire logic eav_strobe_o
);
    logic [2:0] cnt_ff;

    // A started marker always runs to the end of its six-cycle slot.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_ff <= 3'h0;
        else if (cnt_ff != 3'h0 || run_i)
            cnt_ff <= (cnt_ff == 3'h5) ? 3'h0 : cnt_ff + 3'h1;
    end

    // Two cycles high and four low; one marker closes each full line.
    assign eav_strobe_o = (cnt_ff == 3'h1) || (cnt_ff == 3'h2);
endmodule : pixel_source_model

`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the field/line sequencer.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import line_seq_pkg::*;

    logic        clk_i;
    logic        rst_b_i = 1'b0;
    std_t        std_i = std_ntsc;
    logic        master_mode_i = 1'b0;
    logic        blanking_lines_active_enable_i = 1'b0;
    logic        run = 1'b0;
    logic        eav_strobe_i;
    line_kind_t  line_type_o;
    logic [2:0]  field_index_o;
    logic [10:0] line_number_o;
    logic        line_start_o;
    logic        eol_hold_o;
    logic        sc_reset_o;
    logic [9:0]  sc_phase_o;
    int          n_mismatch = 0;
    int          checks = 0;

    video_field_line_sequencer video_field_line_sequencer_i (
        .clk_i, .rst_b_i, .std_i, .master_mode_i,
        .blanking_lines_active_enable_i, .eav_strobe_i, .line_type_o,
        .field_index_o, .line_number_o, .line_start_o, .eol_hold_o,
        .sc_reset_o, .sc_phase_o
    );

    pixel_source_model pixel_source_model_i (
        .clk_i, .rst_b_i, .run_i(run), .eav_strobe_o(eav_strobe_i)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic close_out();
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic wait_start(int lim, output int c);
        for (c = 1; c <= lim; c++)
        begin
            @(posedge clk_i);
            #1;
            if (line_start_o === 1'b1)
                return;
        end
        check("line_start in time", 32'h0, 32'h1);
        close_out();
    endtask : wait_start

    task automatic do_reset(std_t s, logic m, logic v);
        rst_b_i = 1'b0;
        run = 1'b0;
        std_i = s;
        master_mode_i = m;
        blanking_lines_active_enable_i = v;
        repeat (12) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        check("reset line", 32'(line_number_o), 32'h0);
        check("reset field", 32'(field_index_o), 32'h7);
    endtask : do_reset

    function automatic line_kind_t want(std_t s, int n, logic alt, logic v);
        line_kind_t k;
        k = active_video_line;
        if (s == std_ntsc)
            case (n) inside
                [1:3], [7:9], [264:265], [270:271]: k = equalization_line;
                [4:6], [267:268]: k = vertical_sync_line;
                266: k = eq_then_sync_line;
                269: k = sync_then_eq_line;
                272: k = eq_broad_line;
                [10:20], [273:282]: k = black_burst_line;
                263: k = video_then_eq_line;
                default: ;
            endcase
        else if (s == std_pal_m)
            case (n) inside
                [4:6], [261:262], [267:268], [523:525]: k = equalization_line;
                [1:3], [264:265]: k = vertical_sync_line;
                263: k = eq_then_sync_line;
                266: k = sync_then_eq_line;
                269: k = eq_broad_line;
                7, 270: k = blank_no_burst_line;
                8: k = alt ? black_burst_line : blank_no_burst_line;
                [9:17], [271:279]: k = black_burst_line;
                259: k = alt ? active_no_burst_line : active_video_line;
                260: k = video_eq_no_burst_line;
                522: k = alt ? active_video_line : active_no_burst_line;
                default: ;
            endcase
        else
            case (n) inside
                [4:5], [311:312], [316:317], [624:625], [629:630],
                [936:937], [941:942], [1249:1250]: k = equalization_line;
                [1:2], [314:315], [626:627], [939:940]: k = vertical_sync_line;
                3, 628: k = sync_then_eq_line;
                313, 938: k = eq_then_sync_line;
                318, 943: k = eq_broad_line;
                6, 944: k = blank_no_burst_line;
                310, 622: k = active_no_burst_line;
                623, 1248: k = video_eq_no_burst_line;
                [7:22], [319:335], [631:647], [945:960]: k = black_burst_line;
                default: ;
            endcase
        if (v && k == black_burst_line)
            k = active_video_line;
        if (v && k == blank_no_burst_line)
            k = active_no_burst_line;
        return k;
    endfunction : want

    task automatic sweep(std_t s, logic v);
        int last;
        int tot;
        int n;
        int fr;
        int c;
        logic [2:0] f;
        last = (s == std_pal_bgh) ? 1250 : 525;
        tot = (s == std_pal_m) ? 2100 : ((s == std_ntsc) ? 1050 : 2500);
        do_reset(s, 1'b0, v);
        run = 1'b1;
        for (int i = 0; i <= tot; i++)
        begin
            n = i % last + 1;
            fr = (i / last) % (tot / last);
            if (last == 1250)
                f = 3'(4 * fr + (n >= 313) + (n >= 626) + (n >= 938));
            else
                f = 3'(2 * fr + (n >= ((s == std_ntsc) ? 264 : 263)));
            wait_start(20, c);
            check("line", 32'(line_number_o), 32'(n));
            check("field", 32'(field_index_o), 32'(f));
            check("type", 32'(line_type_o), 32'(want(s, n, f[1], v)));
        end
        run = 1'b0;
    endtask : sweep

    task automatic master_check(std_t s, int rl, logic [9:0] ph, int per);
        int c;
        do_reset(s, 1'b1, 1'b0);
        for (int i = 0; i < 6 && line_number_o != 11'(rl); i++)
            wait_start(3000, c);
        check("reset line", 32'(line_number_o), 32'(rl));
        check("sc_reset", 32'(sc_reset_o), 32'h1);
        @(posedge clk_i);
        #1;
        check("phase", 32'(sc_phase_o), 32'(ph));
        check("sc_reset end", 32'(sc_reset_o), 32'h0);
        check("line_start end", 32'(line_start_o), 32'h0);
        wait_start(3000, c);
        // One edge of this line was spent on the phase check above.
        check("period", 32'(c + 1), 32'(per));
        @(posedge clk_i);
        #1;
        if (s == std_ntsc)
            check("ntsc phase", 32'(sc_phase_o), 32'h0);
    endtask : master_check

    task automatic eol_test();
        int c;
        logic [10:0] base;
        do_reset(std_ntsc, 1'b0, 1'b0);
        run = 1'b1;
        wait_start(20, c);
        run = 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        base = line_number_o;
        for (c = 0; c < 3000 && eol_hold_o !== 1'b1; c++)
        begin
            @(posedge clk_i);
            #1;
        end
        if (c == 3000)
        begin
            check("eol_hold in time", 32'h0, 32'h1);
            close_out();
        end
        repeat (50) @(posedge clk_i);
        #1;
        check("eol_hold", 32'(eol_hold_o), 32'h1);
        check("held line", 32'(line_number_o), 32'(base));
        run = 1'b1;
        wait_start(10, c);
        run = 1'b0;
        check("eol_hold end", 32'(eol_hold_o), 32'h0);
        check("next line", 32'(line_number_o), 32'(base + 11'h1));
    endtask : eol_test

    initial
    begin
        #1;
        master_check(std_pal_n, 1, 10'h000, 2560);
        master_check(std_ntsc, 4, 10'h200, 2542);
        master_check(std_pal_m, 4, 10'h000, 2542);
        eol_test();
        sweep(std_ntsc, 1'b0);
        sweep(std_pal_bgh, 1'b0);
        sweep(std_pal_m, 1'b0);
        sweep(std_pal_bgh, 1'b1);
        close_out();
    end
endmodule : testbench

`default_nettype wire
